// ==== rtl/mbtrr_defines.vh ====
`ifndef MBTRR_DEFINES_VH
`define MBTRR_DEFINES_VH
// Frame layout, service codes and exception codes
`define MBTRR_EXC_OFFSET    8'h80
`define MBTRR_SC_RD_HOLD    8'h03
`define MBTRR_SC_RD_INPUT   8'h04
`define MBTRR_SC_WR_SINGLE  8'h06
`define MBTRR_EXC_ILL_FUNC  8'h01
`define MBTRR_EXC_ILL_ADDR  8'h02
`define MBTRR_EXC_ILL_VALUE 8'h03
`define MBTRR_EXC_FAILURE   8'h04
`define MBTRR_MAX_COUNT     8'h7d
`define MBTRR_FIFO_DEPTH    4
`define MBTRR_REG_AW        4
`endif

// ==== rtl/mbtrr_fifo.v ====
`timescale 1ns/10ps
`default_nettype none
module mbtrr_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             ref_clk_in,
   input  wire             arst_n_in,
   input  wire [WIDTH-1:0] wr_data_in,
   input  wire             wr_valid_in,
   output wire             wr_ready_out,
   output wire [WIDTH-1:0] rd_data_out,
   output wire             rd_valid_out,
   input  wire             rd_ready_in
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_q;
   reg [AW-1:0]    rd_ptr_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   // Handshake terms; full and empty come straight from the count
   assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
   assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
   assign rd_data_out  = mem_q[rd_ptr_q];
   assign push         = wr_valid_in & wr_ready_out;
   assign pop          = rd_valid_out & rd_ready_in;

   // Storage has no reset, only pointers and count do
   always @(posedge ref_clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q] <= wr_data_in;
      end
   end

   // Pointers wrap at depth so depth need not be a power of two
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         cnt_q    <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/mbtrr_responder.v ====
// Functional notes
// - Transmit only in answer to a request
// - Decode service code, select the operation
// - Frame: unit byte, service code, data
// - Multi-byte values go high byte first
// - Normal answer echoes the service code
// - Failed request or action gets error answer
// - Service code fixes data presence and length
// - Unit byte is echoed, never used for selection
// - Error answer: code plus 80h, exception code
// - Malformed request drops connection, no answer
`timescale 1ns/10ps
`default_nettype none
`include "mbtrr_defines.vh"
module mbtrr_responder #(
   parameter REG_AW = `MBTRR_REG_AW
) (
   input  wire       ref_clk_in,
   input  wire       arst_n_in,
   input  wire [7:0] rx_data_in,
   input  wire       rx_valid_in,
   input  wire       rx_last_in,
   input  wire       rx_error_in,
   output reg        rx_ready_out,
   output reg  [7:0] tx_data_out,
   output reg        tx_valid_out,
   output reg        tx_last_out,
   input  wire       tx_ready_in,
   output reg        conn_drop_out
);
   localparam NREG = 1 << REG_AW;
   // States
   localparam S_UNIT = 3'h0;
   localparam S_CODE = 3'h1;
   localparam S_DATA = 3'h2;
   localparam S_SKIP = 3'h3;
   localparam S_EXEC = 3'h4;
   localparam S_SEND = 3'h5;

   reg  [2:0]  st_q;
   reg  [7:0]  unit_q;
   reg  [7:0]  service_code_byte_q;
   reg  [7:0]  hdr_q [0:3];
   reg  [2:0]  nhdr_q;
   reg         bad_q;
   reg  [7:0]  exc_q;
   reg  [15:0] regs_q [0:NREG-1];
   reg  [7:0]  rsp_len_q;
   reg  [7:0]  ix_q;
   reg  [8:0]  fifo_wd;
   reg         fifo_wv;
   wire        fifo_wr;
   wire [8:0]  fifo_rd;
   wire        fifo_rv;
   wire        fifo_pop;
   wire [15:0] f_addr;
   wire [15:0] f_val;
   wire [7:0]  rd_cnt;
   wire        rx_take;
   integer     i;

   // Request field view, big-endian pairs
   assign f_addr  = {hdr_q[0], hdr_q[1]};
   assign f_val   = {hdr_q[2], hdr_q[3]};
   assign rd_cnt  = f_val[7:0];
   assign rx_take = rx_valid_in & rx_ready_out;

   // Expected data bytes per service code; zero means unknown
   function [2:0] mbtrr_req_len;
      input [7:0] sc;
      begin
         case (sc)
            `MBTRR_SC_RD_HOLD:   mbtrr_req_len = 3'h4;
            `MBTRR_SC_RD_INPUT:  mbtrr_req_len = 3'h4;
            `MBTRR_SC_WR_SINGLE: mbtrr_req_len = 3'h4;
            default:             mbtrr_req_len = 3'h0;
         endcase
      end
   endfunction

   // Response byte at index k of the frame
   function [7:0] mbtrr_rsp_byte;
      input [7:0] k;
      input [7:0] u;
      input [7:0] sc;
      input [7:0] ex;
      input [15:0] a;
      input [15:0] v;
      input [15:0] rv;
      begin
         if (k == 8'h00) begin
            mbtrr_rsp_byte = u;
         end else if (k == 8'h01) begin
            mbtrr_rsp_byte = (ex != 8'h00) ? (sc + `MBTRR_EXC_OFFSET) : sc;
         end else if (ex != 8'h00) begin
            mbtrr_rsp_byte = ex;
         end else if (sc == `MBTRR_SC_WR_SINGLE) begin
            case (k)
               8'h02:   mbtrr_rsp_byte = a[15:8];
               8'h03:   mbtrr_rsp_byte = a[7:0];
               8'h04:   mbtrr_rsp_byte = v[15:8];
               default: mbtrr_rsp_byte = v[7:0];
            endcase
         end else if (k == 8'h02) begin
            mbtrr_rsp_byte = {v[6:0], 1'b0};
         end else begin
            mbtrr_rsp_byte = k[0] ? rv[15:8] : rv[7:0];
         end
      end
   endfunction

   wire [7:0] reg_ix = f_addr[7:0] + ((ix_q - 8'h03) >> 1);
   wire [15:0] reg_rd = regs_q[reg_ix[REG_AW-1:0]];

   // Request parser and executor; one request handled at a time
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q                <= S_UNIT;
         unit_q              <= 8'h00;
         service_code_byte_q <= 8'h00;
         nhdr_q              <= 3'h0;
         bad_q               <= 1'b0;
         exc_q               <= 8'h00;
         rsp_len_q           <= 8'h00;
         ix_q                <= 8'h00;
         rx_ready_out        <= 1'b0;
         conn_drop_out       <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            hdr_q[i] <= 8'h00;
         end
         for (i = 0; i < NREG; i = i + 1) begin
            regs_q[i] <= 16'h0000;
         end
      end else begin
         conn_drop_out <= 1'b0;
         // Ready falls on the edge that takes the last byte, so nothing slips into exec
         rx_ready_out  <= (st_q <= S_SKIP) & ~(rx_take & rx_last_in);
         case (st_q)
            S_UNIT: begin
               nhdr_q <= 3'h0;
               bad_q  <= 1'b0;
               exc_q  <= 8'h00;
               if (rx_take) begin
                  unit_q <= rx_data_in;
                  // Lone or bad byte is dropped via exec, same timing as every drop
                  bad_q  <= rx_last_in | rx_error_in;
                  st_q   <= rx_last_in ? S_EXEC : S_CODE;
               end
            end
            S_CODE: begin
               if (rx_take) begin
                  service_code_byte_q <= rx_data_in;
                  // Known code cut short, or bad byte: malformed frame
                  if (rx_error_in | (rx_last_in & (mbtrr_req_len(rx_data_in) != 3'h0))) begin
                     bad_q <= 1'b1;
                  end
                  if (mbtrr_req_len(rx_data_in) == 3'h0) begin
                     exc_q <= `MBTRR_EXC_ILL_FUNC;
                  end
                  if (rx_last_in) begin
                     st_q <= S_EXEC;
                  end else begin
                     st_q <= (mbtrr_req_len(rx_data_in) == 3'h0) ? S_SKIP : S_DATA;
                  end
               end
            end
            S_DATA: begin
               if (rx_take) begin
                  hdr_q[nhdr_q[1:0]] <= rx_data_in;
                  nhdr_q             <= nhdr_q + 3'h1;
                  if (nhdr_q == 3'h3) begin
                     bad_q <= bad_q | ~rx_last_in | rx_error_in;
                     st_q  <= rx_last_in ? S_EXEC : S_SKIP;
                  end else if (rx_last_in) begin
                     bad_q <= 1'b1;
                     st_q  <= S_EXEC;
                  end else if (rx_error_in) begin
                     bad_q <= 1'b1;
                  end
               end
            end
            S_SKIP: begin
               // Drains the rest of an unusable frame before judging it
               if (rx_take & rx_last_in) begin
                  st_q <= S_EXEC;
               end
               if (rx_take & ((exc_q == 8'h00) | rx_error_in)) begin
                  bad_q <= 1'b1;
               end
            end
            S_EXEC: begin
               ix_q <= 8'h00;
               if (bad_q) begin
                  conn_drop_out <= 1'b1;
                  st_q          <= S_UNIT;
               end else if (exc_q != 8'h00) begin
                  rsp_len_q <= 8'h03;
                  st_q      <= S_SEND;
               end else if (service_code_byte_q == `MBTRR_SC_WR_SINGLE) begin
                  if (f_addr >= NREG) begin
                     exc_q     <= `MBTRR_EXC_ILL_ADDR;
                     rsp_len_q <= 8'h03;
                  end else begin
                     regs_q[f_addr[REG_AW-1:0]] <= f_val;
                     rsp_len_q                  <= 8'h06;
                  end
                  st_q <= S_SEND;
               end else begin
                  if ((rd_cnt == 8'h00) || (rd_cnt > `MBTRR_MAX_COUNT) || (f_val[15:8] != 8'h00)) begin
                     exc_q     <= `MBTRR_EXC_ILL_VALUE;
                     rsp_len_q <= 8'h03;
                  end else if ({1'b0, f_addr} + {9'h000, rd_cnt} > NREG) begin
                     exc_q     <= `MBTRR_EXC_ILL_ADDR;
                     rsp_len_q <= 8'h03;
                  end else begin
                     rsp_len_q <= 8'h03 + {rd_cnt[6:0], 1'b0};
                  end
                  st_q <= S_SEND;
               end
            end
            S_SEND: begin
               // Bytes only leave while a request is being answered
               if (fifo_wr) begin
                  ix_q <= ix_q + 8'h01;
                  if (ix_q == rsp_len_q - 8'h01) begin
                     st_q <= S_UNIT;
                  end
               end
            end
            default: begin
               st_q <= S_UNIT;
            end
         endcase
      end
   end

   // Response byte builder feeding the FIFO
   always @* begin
      fifo_wv = (st_q == S_SEND);
      fifo_wd = {(ix_q == rsp_len_q - 8'h01),
                 mbtrr_rsp_byte(ix_q, unit_q, service_code_byte_q, exc_q, f_addr,
                                f_val, reg_rd)};
   end

   wire fifo_wrdy;
   assign fifo_wr = fifo_wv & fifo_wrdy;

   mbtrr_fifo #(
      .WIDTH (9),
      .DEPTH (`MBTRR_FIFO_DEPTH),
      .AW    (2)
   ) u_fifo (
      .ref_clk_in   (ref_clk_in),
      .arst_n_in    (arst_n_in),
      .wr_data_in   (fifo_wd),
      .wr_valid_in  (fifo_wv),
      .wr_ready_out (fifo_wrdy),
      .rd_data_out  (fifo_rd),
      .rd_valid_out (fifo_rv),
      .rd_ready_in  (~tx_valid_out | tx_ready_in)
   );
   assign fifo_pop = fifo_rv & (~tx_valid_out | tx_ready_in);

   // Output register stage so every transmit port is a flop
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_data_out  <= 8'h00;
         tx_valid_out <= 1'b0;
         tx_last_out  <= 1'b0;
      end else if (~tx_valid_out | tx_ready_in) begin
         tx_valid_out <= fifo_pop;
         tx_data_out  <= fifo_rd[7:0];
         tx_last_out  <= fifo_rd[8] & fifo_pop;
      end
   end
endmodule
`default_nettype wire

// ==== bench/mbtrr_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module mbtrr_chk (
   input wire logic       ref_clk_in,
   input wire logic       arst_n_in,
   input wire logic [7:0] rx_data_in,
   input wire logic       rx_valid_in,
   input wire logic       rx_last_in,
   input wire logic       rx_error_in,
   input wire logic       rx_ready_out,
   input wire logic [7:0] tx_data_out,
   input wire logic       tx_valid_out,
   input wire logic       tx_last_out,
   input wire logic       tx_ready_in,
   input wire logic       conn_drop_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   wire acc_last = rx_valid_in && rx_ready_out && rx_last_in;
   wire tx_end   = tx_valid_out && tx_ready_in && tx_last_out;
   // Open request; cleared by the drop as well, else a dropped frame would mask a stray answer
   logic pend_q;
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
      if (!arst_n_in)
         pend_q <= 1'b0;
      else if (acc_last)
         pend_q <= 1'b1;
      else if (conn_drop_out || tx_end)
         pend_q <= 1'b0;
   property p_hold;
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out);
   endproperty
   a_hold: assert property (p_hold) else $error("tx byte moved under stall");
   property p_solicit;
      tx_valid_out |-> pend_q;
   endproperty
   a_solicit: assert property (p_solicit) else $error("unsolicited tx byte");
   property p_tail;
      tx_end |=> !tx_valid_out;
   endproperty
   a_tail: assert property (p_tail) else $error("tx after last byte");
   property p_busy;
      acc_last |=> !rx_ready_out;
   endproperty
   a_busy: assert property (p_busy) else $error("rx ready during exec");
   property p_answer;
      acc_last |-> ##[2:4] (tx_valid_out || conn_drop_out);
   endproperty
   a_answer: assert property (p_answer) else $error("no answer to request");
   property p_err;
      acc_last && rx_error_in |-> ##2 conn_drop_out;
   endproperty
   a_err: assert property (p_err) else $error("rx error not dropped");
   property p_drop_one;
      conn_drop_out |=> !conn_drop_out;
   endproperty
   a_drop_one: assert property (p_drop_one) else $error("drop not a pulse");
   property p_drop_silent;
      conn_drop_out |-> !tx_valid_out ##1 !tx_valid_out;
   endproperty
   a_drop_silent: assert property (p_drop_silent) else $error("answer on dropped frame");
   c_drop: cover property (conn_drop_out);
   c_stall: cover property (tx_valid_out && !tx_ready_in);
   c_done: cover property (tx_end);
endmodule
bind mbtrr_responder mbtrr_chk u_chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
   .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .rx_last_in(rx_last_in),
   .rx_error_in(rx_error_in), .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out),
   .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
   .conn_drop_out(conn_drop_out));
`default_nettype wire

// ==== bench/mbtrr_client_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mbtrr_client_model (
   input  wire logic       ref_clk_in,
   input  wire logic [7:0] tx_data_in,
   input  wire logic       tx_valid_in,
   input  wire logic       tx_last_in,
   input  wire logic       stall_in,
   output var logic        tx_ready_out
);
   logic [7:0] got[$];
   int         last_n = 0;
   initial tx_ready_out = 1'b0;
   // Collect answer bytes in wire order; a stall is what backs up the buffer
   always @(posedge ref_clk_in) begin
      if (tx_valid_in && tx_ready_out) begin
         got.push_back(tx_data_in);
         // Byte count at the last flag, so a misplaced end marker shows up
         if (tx_last_in)
            last_n <= got.size();
      end
      tx_ready_out <= !stall_in;
   end
endmodule
`default_nettype wire

// ==== bench/tb_modbus_tcp_request_responder.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_modbus_tcp_request_responder;
   logic ref_clk_in = 0, arst_n_in = 0, rx_valid_in = 0, rx_last_in = 0, rx_error_in = 0;
   logic stall = 0, drop_seen = 0;
   logic [7:0] rx_data_in = 8'h00, tx_data_out;
   wire logic rx_ready_out, tx_valid_out, tx_last_out, tx_ready_in, conn_drop_out;
   int failures = 0, total_checks = 0, cyc = 0;
   logic [7:0] rq[0:7], ex[0:7];
   mbtrr_responder #(.REG_AW(4)) uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .rx_last_in(rx_last_in),
      .rx_error_in(rx_error_in), .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out),
      .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
      .conn_drop_out(conn_drop_out));
   mbtrr_client_model client (.ref_clk_in(ref_clk_in), .tx_data_in(tx_data_out),
      .tx_valid_in(tx_valid_out), .tx_last_in(tx_last_out), .stall_in(stall),
      .tx_ready_out(tx_ready_in));
   always #4 ref_clk_in = ~ref_clk_in;
   task automatic close_out();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Drop watcher and hang guard; a full run needs well under 1000 cycles
   always @(posedge ref_clk_in) begin
      cyc++;
      if (conn_drop_out === 1'b1)
         drop_seen = 1;
      if (cyc == 4000) begin
         failures++;
         close_out();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Request and expected answer, first byte in the top bits
   task automatic setq(input logic [63:0] r, input logic [63:0] e);
      for (int i = 0; i < 8; i++) begin
         rq[i] = r[63-8*i -: 8];
         ex[i] = e[63-8*i -: 8];
      end
   endtask
   // Send n bytes, hold each until taken; m answer bytes, none means a drop
   task automatic xact(input int n, input int m, input logic err);
      int i;
      client.got.delete();
      client.last_n = 0;
      drop_seen = 0;
      for (i = 0; i < n; i++) begin
         rx_data_in = rq[i];
         rx_valid_in = 1;
         rx_last_in = (i == n - 1);
         rx_error_in = err && (i == n - 1);
         while (rx_ready_out !== 1'b1) begin
            @(posedge ref_clk_in);
            #1;
         end
         @(posedge ref_clk_in);
         #1;
      end
      rx_valid_in = 0;
      rx_last_in = 0;
      rx_error_in = 0;
      for (i = 0; i < 60 && client.got.size() < m; i++)
         @(posedge ref_clk_in);
      repeat (6) @(posedge ref_clk_in);
      #1;
      chk(8'(client.got.size()), 8'(m));
      chk(8'(client.last_n), 8'(m));
      for (i = 0; i < m && i < client.got.size(); i++)
         chk(client.got[i], ex[i]);
      chk(drop_seen, m == 0);
   endtask
   task automatic t_write_read();
      setq(64'h1106_0003_a55a_0000, 64'h1106_0003_a55a_0000);
      xact(6, 6, 0);
      setq(64'h2204_0003_0001_0000, 64'h2204_02a5_5a00_0000);
      xact(6, 5, 0);
   endtask
   task automatic t_stall();
      setq(64'h3303_0002_0002_0000, 64'h3303_0400_00a5_5a00);
      stall = 1;
      fork
         xact(6, 7, 0);
         begin
            repeat (24) @(posedge ref_clk_in);
            #1;
            chk(rx_ready_out, 0);
            stall = 0;
         end
      join
   endtask
   task automatic t_errors();
      setq(64'h4410_0000_0001_0000, 64'h4490_0100_0000_0000);
      xact(6, 3, 0);
      setq(64'h5503_0010_0001_0000, 64'h5583_0200_0000_0000);
      xact(6, 3, 0);
      setq(64'h6603_0000_0000_0000, 64'h6683_0300_0000_0000);
      xact(6, 3, 0);
      setq(64'h7704_0000_007e_0000, 64'h7784_0300_0000_0000);
      xact(6, 3, 0);
   endtask
   task automatic t_drops();
      setq(64'h8806_0001_0200_0000, 64'h0);
      xact(5, 0, 0);
      setq(64'h9903_0000_0001_0000, 64'h0);
      xact(6, 0, 1);
      xact(1, 0, 0);
      xact(2, 0, 0);
   endtask
   initial begin
      repeat (6) @(posedge ref_clk_in);
      #1;
      arst_n_in = 1;
      t_write_read();
      t_stall();
      t_errors();
      t_drops();
      close_out();
   end
endmodule
`default_nettype wire
